/* design/pin_port_pkg.sv */
// Constants, register map and types for the pin, button and timer port.
// Assumes a 25 MHz APB clock; all offsets are byte addresses of 32-bit words.
package pin_port_pkg;
  localparam int CLK_PERIOD_NS = 40;
  localparam int US_NS         = 1000;
  localparam int US_CYCLES     = (US_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int MS_US         = 1000;
  localparam int MS_CYCLES     = US_CYCLES * MS_US;
  localparam int PERIOD_MS_MIN = 1;
  localparam int PERIOD_US_MIN = 256;
  localparam int PERIOD_US_RST = 20000;
  localparam int HALT_CODE_MAX = 255;

  localparam logic [7:0] OFF_MODE      = 8'h00;
  localparam logic [7:0] OFF_PULL      = 8'h04;
  localparam logic [7:0] OFF_DOUT      = 8'h08;
  localparam logic [7:0] OFF_PIN_IN    = 8'h0c;
  localparam logic [7:0] OFF_HELD      = 8'h10;
  localparam logic [7:0] OFF_LATCH     = 8'h14;
  localparam logic [7:0] OFF_COUNT     = 8'h18;
  localparam logic [7:0] OFF_DUTY      = 8'h1c;
  localparam logic [7:0] OFF_PERIOD_MS = 8'h20;
  localparam logic [7:0] OFF_PERIOD_US = 8'h24;
  localparam logic [7:0] OFF_UPTIME    = 8'h28;
  localparam logic [7:0] OFF_DELAY     = 8'h2c;
  localparam logic [7:0] OFF_HALT      = 8'h30;
  localparam logic [7:0] OFF_IRQ_STAT  = 8'h34;
  localparam logic [7:0] OFF_IRQ_MASK  = 8'h38;

  // Field positions
  localparam int PIN_LEVEL_BIT = 0;
  localparam int PIN_TOUCH_BIT = 1;
  localparam int PIN_ADC_LSB   = 16;
  localparam int HALTED_BIT    = 8;
  localparam int IRQ_PRESS_LSB = 0;
  localparam int IRQ_DELAY_BIT = 2;
  localparam int IRQ_HALT_BIT  = 3;
  localparam int IRQ_W         = 4;

  typedef enum logic [2:0] {MODE_DIG_IN, MODE_DIG_OUT, MODE_ANALOG_IN, MODE_TOUCH, MODE_PWM} pin_mode_t;
  typedef enum logic [1:0] {BIAS_NONE, BIAS_DOWN, BIAS_UP} bias_t;
  typedef enum logic [1:0] {ST_IDLE, ST_ACK, ST_DELAY} bus_state_t;
endpackage

/* design/pin_pwm_button_port.sv */
// One general-purpose pin with PWM, two push buttons, uptime, delay and halt.
// Assumes APB master on pclk; pin, button, touch and converter inputs are
// synchronous to pclk; button inputs are high while held.
module pin_pwm_button_port
  import pin_port_pkg::*;
#(
  parameter int NBTN      = 2,
  parameter int CNT_W     = 16,
  parameter int DUTY_W    = 10,
  parameter int PERIOD_W  = 20,
  parameter int MS_CYC    = MS_CYCLES
) (
  input  logic              pclk,
  input  logic              presetn,
  input  logic              psel,
  input  logic              penable,
  input  logic              pwrite,
  input  logic [7:0]        paddr,
  input  logic [31:0]       pwdata,
  output logic [31:0]       prdata,
  output logic              pready,
  output logic              pslverr,
  input  logic [NBTN-1:0]   btn_held,
  input  logic              pin_level,
  input  logic              touch_low_res,
  input  logic [DUTY_W-1:0] adc_code,
  output logic              pin_out,
  output logic              pin_oe,
  output logic              pull_up_en,
  output logic              pull_dn_en,
  output logic              halted,
  output logic [7:0]        halt_code,
  output logic              irq
);
  localparam logic [DUTY_W-1:0]   DUTY_FULL = {DUTY_W{1'b1}};
  localparam logic [PERIOD_W-1:0] PER_RST   = PERIOD_W'(PERIOD_US_RST);
  localparam int                  PER_MS_MAX = ((1 << PERIOD_W) - 1) / MS_US;

  bus_state_t            state_q;
  logic                  pready_q, pslverr_q, halted_q, irq_q;
  logic [31:0]           prdata_q, rd_data, delay_cyc_q, ms_cyc_q, uptime_q;
  logic                  hit, setup, commit, wr, rd_done, delay_done;
  logic [15:0]           delay_left_q;
  logic [7:0]            halt_code_q;
  pin_mode_t             mode_q, mode_d;
  bias_t                 bias_q, bias_d;
  logic                  dout_q, dout_d, pin_out_q, pin_oe_q;
  logic                  drive_d, pull_up_q, pull_dn_q;
  logic [NBTN-1:0]       prev_q, latch_q, press;
  logic [CNT_W-1:0]      cnt_q [NBTN];
  logic [DUTY_W-1:0]     duty_q;
  logic [PERIOD_W-1:0]   period_q, period_act_q, hi_act_q, pwm_cnt_q;
  logic [7:0]            us_cyc_q;
  logic                  us_tick;
  logic [IRQ_W-1:0]      stat_q, mask_q, stat_set, stat_d;
  logic [31:0]           ms_prod;

  // Duty scaled over 1024 steps; full code gives a solid high level
  function automatic logic [PERIOD_W-1:0] high_time(input logic [DUTY_W-1:0] d,
                                                    input logic [PERIOD_W-1:0] p);
    logic [DUTY_W+PERIOD_W-1:0] prod;
    prod = {{PERIOD_W{1'b0}}, d} * {{DUTY_W{1'b0}}, p};
    high_time = (d == DUTY_FULL) ? p : prod[DUTY_W +: PERIOD_W];
  endfunction

  function automatic bias_t default_bias(input pin_mode_t m);
    case (m)
      MODE_DIG_IN: default_bias = BIAS_DOWN;
      MODE_TOUCH:  default_bias = BIAS_UP;
      default:     default_bias = BIAS_NONE;
    endcase
  endfunction

  assign setup   = psel & ~penable;
  assign commit  = psel & penable & pready_q;
  assign wr      = commit & pwrite & ~pslverr_q & ~halted_q;
  assign rd_done = commit & ~pwrite & ~pslverr_q;
  assign ms_prod = pwdata * 32'(MS_US);

  // Read mux, sampled in the setup cycle
  always_comb begin
    rd_data = '0;
    hit     = 1'b1;
    case (paddr)
      OFF_MODE:      rd_data = 32'(mode_q);
      OFF_PULL:      rd_data = 32'(bias_q);
      OFF_DOUT:      rd_data = 32'(dout_q);
      OFF_PIN_IN: begin
        rd_data[PIN_LEVEL_BIT] = pin_level;
        rd_data[PIN_TOUCH_BIT] = (mode_q == MODE_TOUCH) & touch_low_res;
        if (mode_q == MODE_ANALOG_IN) begin
          rd_data[PIN_ADC_LSB +: DUTY_W] = adc_code;
        end
      end
      OFF_HELD:      rd_data = 32'(btn_held);
      OFF_LATCH:     rd_data = 32'(latch_q);
      OFF_COUNT: begin
        for (int i = 0; i < NBTN; i++) begin
          rd_data[i*CNT_W +: CNT_W] = cnt_q[i];
        end
      end
      OFF_DUTY:      rd_data = 32'(duty_q);
      OFF_PERIOD_MS: rd_data = 32'(period_q);
      OFF_PERIOD_US: rd_data = 32'(period_q);
      OFF_UPTIME:    rd_data = uptime_q;
      OFF_DELAY:     rd_data = '0;
      OFF_HALT:      rd_data = {23'h000000, halted_q, halt_code_q};
      OFF_IRQ_STAT:  rd_data = 32'(stat_q);
      OFF_IRQ_MASK:  rd_data = 32'(mask_q);
      default:       hit = 1'b0;
    endcase
  end

  // Bus sequencing; a nonzero delay write while not halted holds pready low to stall the master
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state_q      <= ST_IDLE;
      pready_q     <= 1'b0;
      pslverr_q    <= 1'b0;
      prdata_q     <= '0;
      delay_left_q <= '0;
      delay_cyc_q  <= '0;
    end else begin
      case (state_q)
        ST_IDLE: begin
          if (setup) begin
            prdata_q  <= rd_data;
            pslverr_q <= ~hit;
            if (pwrite && paddr == OFF_DELAY && pwdata[15:0] != '0 && !halted_q) begin
              state_q      <= ST_DELAY;
              delay_left_q <= pwdata[15:0];
              delay_cyc_q  <= '0;
            end else begin
              state_q  <= ST_ACK;
              pready_q <= 1'b1;
            end
          end
        end
        ST_ACK: begin
          pready_q <= 1'b0;
          state_q  <= ST_IDLE;
        end
        ST_DELAY: begin
          if (delay_cyc_q == 32'(MS_CYC - 1)) begin
            delay_cyc_q  <= '0;
            delay_left_q <= delay_left_q - 16'h0001;
            if (delay_left_q == 16'h0001) begin
              state_q  <= ST_ACK;
              pready_q <= 1'b1;
            end
          end else begin
            delay_cyc_q <= delay_cyc_q + 32'h00000001;
          end
        end
        default: state_q <= ST_IDLE;
      endcase
    end
  end

  assign delay_done = (state_q == ST_DELAY) && (delay_cyc_q == 32'(MS_CYC - 1)) && (delay_left_q == 16'h0001);

  // Uptime in ms; free running from reset release
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ms_cyc_q <= '0;
      uptime_q <= '0;
    end else if (ms_cyc_q == 32'(MS_CYC - 1)) begin
      ms_cyc_q <= '0;
      uptime_q <= uptime_q + 32'h00000001;
    end else begin
      ms_cyc_q <= ms_cyc_q + 32'h00000001;
    end
  end

  // Buttons; only bits that were reported are cleared, so a press in flight survives
  assign press = btn_held & ~prev_q;
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prev_q  <= '0;
      latch_q <= '0;
      for (int i = 0; i < NBTN; i++) begin
        cnt_q[i] <= '0;
      end
    end else begin
      prev_q <= btn_held;
      if (rd_done && paddr == OFF_LATCH) begin
        latch_q <= (latch_q & ~prdata_q[NBTN-1:0]) | press;
      end else begin
        latch_q <= latch_q | press;
      end
      for (int i = 0; i < NBTN; i++) begin
        if (rd_done && paddr == OFF_COUNT) begin
          cnt_q[i] <= cnt_q[i] - prdata_q[i*CNT_W +: CNT_W] + CNT_W'(press[i]);
        end else begin
          cnt_q[i] <= cnt_q[i] + CNT_W'(press[i]);
        end
      end
    end
  end

  // Next pin mode, bias and level; the pull outputs are registered from these
  always_comb begin
    mode_d = mode_q;
    bias_d = bias_q;
    dout_d = dout_q;
    if (wr) begin
      case (paddr)
        OFF_MODE: begin
          if (pwdata[2:0] <= 3'(MODE_PWM)) begin
            mode_d = pin_mode_t'(pwdata[2:0]);
            bias_d = default_bias(pin_mode_t'(pwdata[2:0]));
          end
        end
        OFF_PULL: begin
          if (pwdata[1:0] <= 2'(BIAS_UP)) begin
            mode_d = MODE_DIG_IN;
            bias_d = bias_t'(pwdata[1:0]);
          end
        end
        OFF_DOUT: begin
          dout_d = pwdata[0];
          mode_d = MODE_DIG_OUT;
        end
        default: ;
      endcase
    end
  end

  assign drive_d = (mode_q == MODE_DIG_OUT) || (mode_q == MODE_PWM);

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      mode_q <= MODE_DIG_IN;
      bias_q <= BIAS_DOWN;
      dout_q <= 1'b0;
    end else begin
      mode_q <= mode_d;
      bias_q <= bias_d;
      dout_q <= dout_d;
    end
  end

  // PWM settings; out-of-range periods are ignored
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      duty_q   <= '0;
      period_q <= PER_RST;
    end else if (wr) begin
      case (paddr)
        OFF_DUTY: duty_q <= pwdata[DUTY_W-1:0];
        OFF_PERIOD_MS: begin
          if (pwdata >= 32'(PERIOD_MS_MIN) && pwdata <= 32'(PER_MS_MAX)) begin
            period_q <= ms_prod[PERIOD_W-1:0];
          end
        end
        OFF_PERIOD_US: begin
          if (pwdata >= 32'(PERIOD_US_MIN) && pwdata < (32'h1 << PERIOD_W)) begin
            period_q <= pwdata[PERIOD_W-1:0];
          end
        end
        default: ;
      endcase
    end
  end

  // Microsecond enable for the PWM counter
  assign us_tick = (us_cyc_q == 8'(US_CYCLES - 1));
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      us_cyc_q <= '0;
    end else begin
      us_cyc_q <= us_tick ? 8'h00 : us_cyc_q + 8'h01;
    end
  end

  // Duty takes effect only at a period boundary to avoid runt pulses; a shorter new period takes effect sooner
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pwm_cnt_q    <= '0;
      period_act_q <= PER_RST;
      hi_act_q     <= '0;
    end else if (us_tick) begin
      // A shorter new period ends a long running one early
      if (pwm_cnt_q >= period_act_q - PERIOD_W'(1) || pwm_cnt_q >= period_q - PERIOD_W'(1)) begin
        pwm_cnt_q    <= '0;
        period_act_q <= period_q;
        hi_act_q     <= high_time(duty_q, period_q);
      end else begin
        pwm_cnt_q <= pwm_cnt_q + PERIOD_W'(1);
      end
    end
  end

  // Pulls use the next bias so a mode write drops them one edge before the drive rises
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pin_out_q <= 1'b0;
      pin_oe_q  <= 1'b0;
      pull_up_q <= 1'b0;
      pull_dn_q <= 1'b1;
    end else begin
      pin_oe_q  <= drive_d;
      pin_out_q <= (mode_q == MODE_PWM) ? (pwm_cnt_q < hi_act_q) : dout_q;
      pull_up_q <= (bias_d == BIAS_UP) && !drive_d;
      pull_dn_q <= (bias_d == BIAS_DOWN) && !drive_d;
    end
  end

  // Halt state lasts until reset
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      halted_q    <= 1'b0;
      halt_code_q <= '0;
    end else if (wr && paddr == OFF_HALT && pwdata <= 32'(HALT_CODE_MAX)) begin
      halted_q    <= 1'b1;
      halt_code_q <= pwdata[7:0];
    end
  end

  // Interrupts; status clears on read of reported bits, new events win
  always_comb begin
    stat_set = '0;
    stat_set[IRQ_PRESS_LSB +: NBTN] = press;
    stat_set[IRQ_DELAY_BIT] = delay_done;
    stat_set[IRQ_HALT_BIT]  = wr && paddr == OFF_HALT && pwdata <= 32'(HALT_CODE_MAX);
    stat_d = stat_q | stat_set;
    if (rd_done && paddr == OFF_IRQ_STAT) begin
      stat_d = (stat_q & ~prdata_q[IRQ_W-1:0]) | stat_set;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      stat_q <= '0;
      mask_q <= '0;
      irq_q  <= 1'b0;
    end else begin
      stat_q <= stat_d;
      if (wr && paddr == OFF_IRQ_MASK) begin
        mask_q <= pwdata[IRQ_W-1:0];
      end
      irq_q <= |(stat_d & mask_q);
    end
  end

  assign prdata     = prdata_q;
  assign pready     = pready_q;
  assign pslverr    = pslverr_q;
  assign pin_out    = pin_out_q;
  assign pin_oe     = pin_oe_q;
  assign pull_up_en = pull_up_q;
  assign pull_dn_en = pull_dn_q;
  assign halted     = halted_q;
  assign halt_code  = halt_code_q;
  assign irq        = irq_q;
endmodule

/* sim/pin_port_monitor.sv */
// Checker for the pin port: bus timing, bias, drive, halt and interrupt mask.
// Bound to the port module by the bind below; sees its ports only.
module pin_port_monitor
  import pin_port_pkg::*;
(
  input wire logic        pclk,
  input wire logic        presetn,
  input wire logic        psel,
  input wire logic        penable,
  input wire logic        pwrite,
  input wire logic [7:0]  paddr,
  input wire logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic        pready,
  input wire logic        pslverr,
  input wire logic        pin_out,
  input wire logic        pin_oe,
  input wire logic        pull_up_en,
  input wire logic        pull_dn_en,
  input wire logic        halted,
  input wire logic [7:0]  halt_code,
  input wire logic        irq
);
  logic bit_q;
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  sequence setup_s; psel && !penable; endsequence
  sequence wr_s; psel && penable && pready && pwrite && !halted; endsequence
  sequence rd_s; psel && penable && pready && !pwrite; endsequence
  // Last written drive level, for comparison two cycles on
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) bit_q <= 1'b0;
    else if (psel && penable && pready && pwrite && !halted && paddr == OFF_DOUT) bit_q <= pwdata[0];
  end
  chk_ready_next: assert property (setup_s ##0 paddr != OFF_DELAY |=> pready)
    else $error("ready missing after setup");
  chk_ready_pulse: assert property (pready |=> !pready) else $error("ready held too long");
  chk_delay_stall: assert property (setup_s ##0 (pwrite && paddr == OFF_DELAY && pwdata[15:0] != 16'h0000 && !halted)
    |=> !pready [*8]) else $error("delay answered too soon");
  chk_err_map: assert property (psel && penable && pready && paddr[1:0] == 2'b00
    |-> pslverr == (paddr > OFF_IRQ_MASK)) else $error("error flag wrong");
  chk_drive_bias: assert property (pin_oe |-> !pull_up_en && !pull_dn_en) else $error("bias while driving");
  chk_touch_bias: assert property (wr_s ##0 (paddr == OFF_MODE && pwdata[2:0] == 3'd3)
    |-> ##2 pull_up_en && !pull_dn_en) else $error("touch mode bias wrong");
  chk_pull_mode: assert property (wr_s ##0 (paddr == OFF_PULL && pwdata[1:0] == 2'd1)
    |-> ##2 pull_dn_en && !pull_up_en && !pin_oe) else $error("pull select wrong");
  chk_dout_drive: assert property (wr_s ##0 paddr == OFF_DOUT |-> ##2 pin_oe && pin_out == bit_q)
    else $error("pin drive wrong");
  chk_halt_take: assert property (wr_s ##0 (paddr == OFF_HALT && pwdata <= 32'd255)
    |=> halted && {24'h0, halt_code} == $past(pwdata)) else $error("halt not taken");
  chk_halt_hold: assert property (halted |=> halted && $stable(halt_code)) else $error("halt left");
  chk_irq_mask: assert property (wr_s ##0 (paddr == OFF_IRQ_MASK && pwdata[3:0] == 4'h0) |-> ##2 !irq)
    else $error("masked interrupt seen");
  chk_delay_read: assert property (rd_s ##0 paddr == OFF_DELAY |-> prdata == 32'h0)
    else $error("delay read not zero");
endmodule

bind pin_pwm_button_port pin_port_monitor i_pin_port_monitor (
  .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
  .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr), .pin_out(pin_out), .pin_oe(pin_oe),
  .pull_up_en(pull_up_en), .pull_dn_en(pull_dn_en), .halted(halted), .halt_code(halt_code), .irq(irq));

/* sim/pin_port_partner.sv */
// Outside world of the pin port: buttons, an external driver, touch pad, converter.
// The bench commands each part; the pin level resolves from every driver.
module pin_port_partner (
  input  wire logic       pclk,
  input  wire logic [1:0] btn_cmd,
  input  wire logic       ext_en,
  input  wire logic       ext_val,
  input  wire logic       touch_cmd,
  input  wire logic [9:0] adc_cmd,
  input  wire logic       pin_oe,
  input  wire logic       pin_out,
  input  wire logic       pull_up_en,
  input  wire logic       pull_dn_en,
  output logic      [1:0] btn_held,
  output logic            pin_level,
  output logic            touch_low_res,
  output logic      [9:0] adc_code
);
  logic flip_q = 1'b0;
  // Floating pin wanders; never show a stale level
  always @(posedge pclk) flip_q <= ~flip_q;
  assign btn_held      = btn_cmd;
  assign touch_low_res = touch_cmd;
  assign adc_code      = adc_cmd;
  // No display shares this pin; the outside driver takes it only when enabled
  assign pin_level     = pin_oe ? pin_out : ext_en ? ext_val : pull_up_en ? 1'b1 : pull_dn_en ? 1'b0 : flip_q;
endmodule

/* sim/test_pin_pwm_button_port.sv */
// Self-checking bench: buttons, pin modes, period, delay, uptime and halt.
// Drives APB and the partner; bus results are checked through a queue.
module test_pin_pwm_button_port
  import pin_port_pkg::*;
();
  timeunit 1ns;
  timeprecision 1ns;
  logic        pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
  logic        ext_en = 1'b0, ext_val = 1'b0, touch_cmd = 1'b0;
  logic [1:0]  btn_cmd = 2'b00, btn_held;
  logic [7:0]  paddr = 8'h00, halt_code;
  logic [9:0]  adc_cmd = 10'h000, adc_code;
  logic [31:0] pwdata = 32'h0, prdata, last_rd, v;
  logic [33:0] e_now, exp_q[$];
  logic        pready, pslverr, pin_level, touch_low_res, pin_out, pin_oe, pull_up_en, pull_dn_en, halted, irq;
  int          num_errors = 0, checked = 0, wait_n, k, hi_n;

  always #20 pclk = ~pclk;

  pin_pwm_button_port #(.MS_CYC(50)) i_pin_pwm_button_port (
    .pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr, .btn_held,
    .pin_level, .touch_low_res, .adc_code, .pin_out, .pin_oe, .pull_up_en, .pull_dn_en, .halted, .halt_code, .irq);
  pin_port_partner i_pin_port_partner (
    .pclk, .btn_cmd, .ext_en, .ext_val, .touch_cmd, .adc_cmd, .pin_oe, .pin_out, .pull_up_en, .pull_dn_en,
    .btn_held, .pin_level, .touch_low_res, .adc_code);

  task automatic check(input string nm, input logic [31:0] e, input logic [31:0] g);
    checked++;
    if (g !== e) begin
      num_errors++;
      $display("[ERR] %s expected %h seen %h", nm, e, g);
    end
  endtask
  task automatic end_sim;
    $display("checks %0d mismatches %0d", checked, num_errors);
    if (num_errors == 0 && checked > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask
  // Caller enters just after a rising edge; request held until pready
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d, input logic [33:0] e);
    exp_q.push_back(e);
    psel <= 1'b1; penable <= 1'b0; pwrite <= w; paddr <= a; pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    wait_n = 0;
    do begin @(posedge pclk); wait_n++; end while (pready !== 1'b1 && wait_n < 20000);
    if (wait_n >= 20000) begin num_errors++; end_sim(); end
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d); apb(1'b1, a, d, 34'h0); endtask
  task automatic rd(input logic [7:0] a, input logic [31:0] e); apb(1'b0, a, 32'h0, {2'b10, e}); endtask
  task automatic idle(input int n); psel <= 1'b0; penable <= 1'b0; repeat (n) @(posedge pclk); endtask
  task automatic press(input int b);
    btn_cmd[b] <= 1'b1; repeat (3) @(posedge pclk);
    btn_cmd[b] <= 1'b0; repeat (3) @(posedge pclk);
  endtask

  always @(posedge pclk) begin
    if (psel && penable && pready === 1'b1) begin
      if (exp_q.size() == 0) check("queue", 32'h0, 32'h1);
      else begin
        e_now = exp_q.pop_front();
        last_rd = prdata;
        check("pslverr", 32'(e_now[32]), 32'(pslverr));
        if (e_now[33]) check("prdata", e_now[31:0], prdata);
      end
    end
  end

  initial begin
    v = $urandom(32'h0b2555e7);
    repeat (16) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    wr(OFF_IRQ_MASK, 32'h3);
    k = 1 + $urandom % 4;
    btn_cmd[1] <= 1'b1;
    idle(1);
    repeat (k) press(0);
    check("irq", 32'h1, 32'(irq));
    rd(OFF_HELD, 32'h2);
    rd(OFF_LATCH, 32'h3);
    rd(OFF_LATCH, 32'h0);
    rd(OFF_COUNT, {16'h1, 16'(k)});
    rd(OFF_COUNT, 32'h0);
    rd(OFF_IRQ_STAT, 32'h3);
    wr(OFF_IRQ_MASK, 32'h0);
    btn_cmd[1] <= 1'b0;
    idle(3);
    press(0);
    check("irq", 32'h0, 32'(irq));
    rd(OFF_IRQ_STAT, 32'h1);
    $display("test buttons done");
    wr(OFF_MODE, 32'h0);
    rd(OFF_PIN_IN, 32'h0);
    v = $urandom % 2;
    ext_en <= 1'b1;
    ext_val <= v[0];
    adc_cmd <= 10'($urandom);
    idle(2);
    rd(OFF_PIN_IN, v);
    wr(OFF_MODE, 32'h2);
    idle(2);
    check("bias", 32'h0, {30'h0, pull_up_en, pull_dn_en});
    rd(OFF_PIN_IN, {6'h0, adc_cmd, 15'h0, ext_val});
    ext_en <= 1'b0;
    touch_cmd <= 1'b1;
    wr(OFF_MODE, 32'h3);
    rd(OFF_PIN_IN, 32'h3);
    touch_cmd <= 1'b0;
    idle(2);
    check("bias", 32'h2, {30'h0, pull_up_en, pull_dn_en});
    rd(OFF_PIN_IN, 32'h1);
    wr(OFF_PULL, 32'h1);
    rd(OFF_MODE, 32'h0);
    wr(OFF_DOUT, v);
    idle(3);
    check("drive", {30'h0, 1'b1, v[0]}, {30'h0, pin_oe, pin_out});
    rd(OFF_MODE, 32'h1);
    $display("test pin modes done");
    wr(OFF_PERIOD_MS, 32'h1);
    rd(OFF_PERIOD_MS, 32'd1000);
    wr(OFF_PERIOD_MS, 32'h0);
    wr(OFF_PERIOD_US, 32'd255);
    rd(OFF_PERIOD_US, 32'd1000);
    wr(OFF_PERIOD_US, 32'd256);
    rd(OFF_PERIOD_US, 32'd256);
    $display("test period done");
    v = $urandom % 1024;
    wr(OFF_DUTY, v);
    wr(OFF_MODE, 32'h4);
    rd(OFF_DUTY, v);
    idle(2 * PERIOD_US_MIN * US_CYCLES);
    check("pwm oe", 32'h2, {30'h0, pin_oe, pull_up_en | pull_dn_en});
    k = 0;
    repeat (PERIOD_US_MIN * US_CYCLES) begin
      @(posedge pclk);
      if (pin_out === 1'b1) k++;
    end
    hi_n = (v == 32'd1023) ? PERIOD_US_MIN : int'(v) * PERIOD_US_MIN / 1024;
    check("pwm high", 32'(hi_n * US_CYCLES), 32'(k));
    wr(OFF_DOUT, 32'h0);
    $display("test pwm done");
    wr(OFF_IRQ_MASK, 32'h4);
    apb(1'b0, OFF_UPTIME, 32'h0, 34'h0);
    idle(1);
    v = last_rd;
    wr(OFF_DELAY, 32'h3);
    check("stall", 32'h1, 32'(wait_n inside {[149:152]}));
    apb(1'b0, OFF_UPTIME, 32'h0, 34'h0);
    idle(1);
    check("uptime", 32'h1, 32'((last_rd - v) inside {[32'd3:32'd4]}));
    check("irq", 32'h1, 32'(irq));
    rd(OFF_IRQ_STAT, 32'h4);
    $display("test delay done");
    wr(OFF_IRQ_MASK, 32'h8);
    wr(OFF_HALT, 32'd300);
    rd(OFF_DELAY, 32'h0);
    check("halted", 32'h0, 32'(halted));
    k = $urandom % 256;
    wr(OFF_HALT, k);
    wr(OFF_PULL, 32'h2);
    idle(2);
    check("halt", {23'h0, 1'b1, 8'(k)}, {23'h0, halted, halt_code});
    check("irq", 32'h1, 32'(irq));
    rd(OFF_HALT, {23'h0, 1'b1, 8'(k)});
    rd(OFF_MODE, 32'h1);
    rd(OFF_IRQ_STAT, 32'h8);
    apb(1'b0, 8'h3c, 32'h0, {2'b01, 32'h0});
    idle(1);
    presetn <= 1'b0;
    repeat (2) @(posedge pclk);
    check("reset", 32'h1, {30'h0, halted, pull_dn_en});
    $display("test halt done");
    end_sim();
  end
endmodule
